// file: rtl/smc_pkg.sv
// Package: constants and types of the sync modem character controller
// Functional notes
// RQ1: Received bits shift into an 8-bit register; each byte raises a request.
// RQ2: Status bit 10 is one when the byte has an even count of ones.
// RQ3: I/O reset or carrier off sends input to idle; idle watches carrier.
// RQ4: Armed on carrier while idle, framing failure, or record separator.
// RQ5: Armed input watches data; first one-to-zero step starts framing.
// RQ6: Framing hunts bitwise for sync, then loads the next eight bits.
// RQ7: Second sync byte enters run and requests; otherwise back to armed.
// RQ8: Run holds until carrier drops (idle) or record separator (armed).
// RQ9: First sync byte is dropped; host reads the second one to clear it.
// RQ10: Input timing error when a byte completes before the last was read.
// RQ11: Data read puts first bit on A15, last on A08, right byte zero.
// RQ12: Byte and parity stay seven bit times; parity reading is optional.
// RQ13: Host byte accepted only when holding register empty and modem ready.
// RQ14: On clear to send, holding moves to shifter and output requests.
// RQ15: Output request unanswered for seven bit clocks sets output error.
// RQ16: Transmit data line holds one whenever nothing is being sent.
// RQ17: Output bytes go out unchanged, no parity made or checked.
// RQ18: Auto-dial presents bits 08 to 11 as BCD digit; 12-15 ignored.
// RQ19: Auto-dial raises an output request each time the dialer wants a digit.
// RQ20: Host issues dialing complete after the final digit.
// RQ21: Two I/O addresses share upper seven bits; LSB one means input.
// RQ22: Input and output request enables are set and cleared separately.
// RQ23: Data read acknowledged only with new byte and no input error.
// RQ24: Record separator to input address (XXX1) drops lock to armed.
package smc_pkg;
    // Bus register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_RESULT = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    // Instruction word fields
    localparam int INSTR_OP_LSB = 30;
    localparam int INSTR_ADR_LSB = 16;
    localparam logic [1:0] OP_CMD = 2'h0;
    localparam logic [1:0] OP_DWR = 2'h1;
    localparam logic [1:0] OP_DRD = 2'h2;
    localparam logic [1:0] OP_SRD = 2'h3;
    // Command codes, accumulator low nibble
    localparam logic [3:0] CMD_ONE = 4'h1;
    localparam logic [3:0] CMD_INH = 4'h4;
    localparam logic [3:0] CMD_OFF = 4'h5;
    localparam logic [3:0] CMD_ALW = 4'h8;
    localparam logic [3:0] CMD_ON = 4'h9;
    localparam logic [3:0] CMD_DONE = 4'hD;
    // Result and status bit positions
    localparam int RES_ACK = 16;
    localparam int ST_DSR = 15;
    localparam int ST_ERR = 13;
    localparam int ST_LINE = 12;
    localparam int ST_NEXT = 11;
    localparam int ST_PAR = 10;
    // Timing counts in serial bit intervals and bus response codes
    localparam logic [2:0] LATE_BITS = 3'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_FRAME, RX_RUN} smc_rx_e;
endpackage

// file: rtl/smc_tx_if.sv
// Interface: holding register to output shifter handoff
`timescale 1ns/1ps
`default_nettype none
interface smc_tx_if;
    logic bitTick;
    logic load;
    logic [7:0] byteIn;
    logic ready;
    logic txBit;
    modport ctl (output bitTick, load, byteIn, input ready, txBit);
    modport shf (input bitTick, load, byteIn, output ready, txBit);
endinterface
`default_nettype wire

// file: rtl/smc_tx_shift.sv
// Output shift register driving the modem transmit data line
`timescale 1ns/1ps
`default_nettype none
module smc_tx_shift
    import smc_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic reset_n, // Async reset, active low
    smc_tx_if.shf tx // Handoff from controller
);
    logic [7:0] sr_q;
    logic [3:0] cnt_q;
    logic txBit_q;

    // Load a byte, shift one bit per tick, mark when empty
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sr_q <= 8'h00;
            cnt_q <= 4'h0;
            txBit_q <= 1'b1;
        end else if (tx.load && cnt_q == 4'h0) begin
            sr_q <= tx.byteIn; // RQ17
            cnt_q <= BYTE_BITS;
        end else if (tx.bitTick) begin
            if (cnt_q != 4'h0) begin
                txBit_q <= sr_q[7];
                sr_q <= {sr_q[6:0], 1'b0};
                cnt_q <= cnt_q - 4'h1;
            end else begin
                txBit_q <= 1'b1; // RQ16
            end
        end
    end

    assign tx.ready = (cnt_q == 4'h0);
    assign tx.txBit = txBit_q;

    property p_mark;
        @(posedge clock) disable iff (!reset_n)
        tx.bitTick && cnt_q == 4'h0 && !tx.load |=> txBit_q;
    endproperty
    a_mark: assert property (p_mark) // RQ16
        else $error("transmit line not at mark while idle");
endmodule
`default_nettype wire

// file: rtl/smc_ctrl.sv
// Top: sync modem character controller with AXI4-Lite host channel
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl
    import smc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h21, // Arbitrary I/O address
    parameter logic [7:0] SYNC_CHAR = 8'h16 // Sync character
) (
    input wire logic clock, // 200 MHz clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [7:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [7:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic rxClk, // Modem receive clock
    input wire logic rxData, // Modem receive data
    input wire logic carrierOn, // Carrier detector
    input wire logic txClk, // Modem transmit clock
    input wire logic clearToSend, // Clear to send
    input wire logic dataSetReady, // Data set ready
    input wire logic dialNextReq, // Auto-dialer wants next digit
    output logic txData, // Modem transmit data
    output logic requestToSend, // Request to send
    output logic terminalReady, // Terminal ready
    output logic [3:0] dialDigit, // BCD digit to auto-dialer
    output logic inSvcReq, // Input service request
    output logic outSvcReq // Output service request
);
    smc_tx_if tx ();
    smc_rx_e rxState_q;
    logic [6:0] meta_q, sync_q, prev_q;
    logic rxClkS, rxDataS, carrierS, txClkS, ctsS, dsrS, nextS;
    logic rxEdge, txEdge, nextEdge, dsrEdge;
    logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rdata_q, result_q;
    logic [1:0] rresp_q;
    logic wrGo, instrGo, hit, toIn;
    logic [1:0] op;
    logic [15:0] acc;
    logic [3:0] code;
    logic cmdIn, cmdOut, callOk, outCmdAck, rdAck, wrAck, holdFree;
    logic rsep, byteDone, rxLoad, rxLate, inStRd, outStRd;
    logic [7:0] rxSr_q, shNext, rxHold_q, holdByte_q;
    logic [2:0] bitCnt_q, lateCnt_q;
    logic locked_q, rxFull_q, parity_q, inErr_q, inReq_q;
    logic holdFull_q, outReq_q, txWait_q, outErr_q;
    logic inEn_q, outEn_q, rts_q, dtr_q, dialMode_q, dialPend_q;
    logic [3:0] dialDigit_q;
    logic [15:0] inStat, outStat;

    // Two-stage synchronisers for all modem pins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= 7'h00;
            sync_q <= 7'h00;
            prev_q <= 7'h00;
        end else begin
            meta_q <= {dialNextReq, dataSetReady, clearToSend, txClk,
                       carrierOn, rxData, rxClk};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
    assign {nextS, dsrS, ctsS, txClkS, carrierS, rxDataS, rxClkS} = sync_q;
    assign rxEdge = rxClkS && !prev_q[0];
    assign txEdge = !txClkS && prev_q[3];
    assign dsrEdge = dsrS != prev_q[5];
    assign nextEdge = nextS && !prev_q[6];

    // Write channel: address and data taken in either order
    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign wrGo = awHeld_q && wHeld_q && !bvalid_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
        end else begin
            if (awvalid && awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= awaddr;
            end else if (wrGo) begin
                awHeld_q <= 1'b0;
            end
            if (wvalid && wready && wstrb == 4'hF) begin
                wHeld_q <= 1'b1;
                wData_q <= wdata;
            end else if (wvalid && wready) begin
                wHeld_q <= 1'b1;
                wData_q <= 32'h00000000; // Partial write: no-op
            end else if (wrGo) begin
                wHeld_q <= 1'b0;
            end
            if (wrGo) begin
                bvalid_q <= 1'b1;
            end else if (bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign bvalid = bvalid_q;
    assign bresp = (awAddr_q == OFF_INSTR) ? RESP_OKAY : RESP_SLVERR;

    // Instruction decode of the emulated host channel
    assign instrGo = wrGo && awAddr_q == OFF_INSTR;
    assign op = wData_q[INSTR_OP_LSB +: 2];
    assign hit = wData_q[INSTR_ADR_LSB + 1 +: 7] == DEV_ADDR; // RQ21
    assign toIn = wData_q[INSTR_ADR_LSB]; // RQ21
    assign acc = wData_q[15:0];
    assign code = acc[3:0];
    assign cmdIn = instrGo && hit && op == OP_CMD && toIn;
    assign cmdOut = instrGo && hit && op == OP_CMD && !toIn;
    assign callOk = dtr_q && !carrierS;
    assign outCmdAck = cmdOut && (code != CMD_ONE || dsrS)
                       && (code != CMD_ON || callOk);
    assign rsep = cmdIn && code == CMD_ONE; // RQ24
    assign rdAck = instrGo && hit && op == OP_DRD && toIn
                   && rxFull_q && !inErr_q; // RQ23
    assign holdFree = !holdFull_q && !outErr_q
                      && (dialMode_q ? dialPend_q : (dsrS && rts_q));
    assign wrAck = instrGo && hit && op == OP_DWR && !toIn
                   && holdFree; // RQ13
    assign inStRd = instrGo && hit && op == OP_SRD && toIn;
    assign outStRd = instrGo && hit && op == OP_SRD && !toIn;
    assign inStat = {2'b00, inErr_q, carrierS, 1'b0, parity_q, 10'h000};
    assign outStat = {dsrS, 1'b0, outErr_q, ctsS, dialPend_q, 11'h000};

    // Command effects on enables and modem controls
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inEn_q <= 1'b0;
            outEn_q <= 1'b0;
            rts_q <= 1'b0;
            dtr_q <= 1'b0;
            dialMode_q <= 1'b0;
        end else begin
            if (cmdIn && code == CMD_INH) inEn_q <= 1'b0; // RQ22
            if (cmdIn && code == CMD_ALW) inEn_q <= 1'b1; // RQ22
            if (cmdOut && code == CMD_INH) outEn_q <= 1'b0; // RQ22
            if (cmdOut && code == CMD_ALW) outEn_q <= 1'b1; // RQ22
            if (cmdIn && code == CMD_ON) dtr_q <= 1'b1;
            if (cmdIn && code == CMD_OFF) dtr_q <= 1'b0;
            if (outCmdAck && code == CMD_ONE) rts_q <= 1'b1;
            if (cmdOut && code == CMD_OFF) rts_q <= 1'b0;
            if (outCmdAck && code == CMD_ON) dialMode_q <= 1'b1;
            if (cmdOut && code == CMD_DONE) dialMode_q <= 1'b0;
        end
    end

    // Result word of the last instruction
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            result_q <= 32'h00000000;
        end else if (instrGo) begin
            result_q <= 32'h00000000;
            if (rdAck) begin
                result_q[RES_ACK] <= 1'b1;
                result_q[15:8] <= rxHold_q; // RQ11
            end else if (inStRd) begin
                result_q[15:0] <= inStat;
            end else if (outStRd) begin
                result_q[15:0] <= outStat;
            end else if (wrAck || cmdIn || outCmdAck) begin
                result_q[RES_ACK] <= 1'b1;
            end
        end
    end

    // Read channel with registered data
    assign arready = !rvalid_q;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (araddr)
                OFF_RESULT: rdata_q <= result_q;
                OFF_STATUS: rdata_q <= {22'h000000, holdFull_q,
                    dialMode_q, rxState_q, locked_q, rxFull_q,
                    outSvcReq, inSvcReq, 2'b00};
                default: begin
                    rdata_q <= 32'h00000000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // Input sequencer: idle, armed, framing, run
    assign shNext = {rxSr_q[6:0], rxDataS}; // RQ1
    assign byteDone = rxEdge && bitCnt_q == 3'h7
        && (rxState_q == RX_RUN || (rxState_q == RX_FRAME && locked_q));
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxState_q <= RX_IDLE;
        end else if (!carrierS) begin
            rxState_q <= RX_IDLE; // RQ3 RQ8
        end else begin
            case (rxState_q)
                RX_IDLE: rxState_q <= RX_ARMED; // RQ4
                RX_ARMED: begin
                    if (prev_q[1] && !rxDataS) rxState_q <= RX_FRAME; // RQ5
                end
                RX_FRAME: begin
                    if (rsep) begin
                        rxState_q <= RX_ARMED; // RQ24
                    end else if (byteDone) begin
                        rxState_q <= (shNext == SYNC_CHAR) ? RX_RUN
                                     : RX_ARMED; // RQ7
                    end
                end
                RX_RUN: begin
                    if (rsep) rxState_q <= RX_ARMED; // RQ8 RQ24
                end
                default: rxState_q <= RX_IDLE;
            endcase
        end
    end

    // Sync hunt, lock and bit counting
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxSr_q <= 8'hFF;
            locked_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (rxState_q == RX_IDLE || rxState_q == RX_ARMED) begin
            rxSr_q <= 8'hFF;
            locked_q <= 1'b0;
            bitCnt_q <= 3'h0;
        end else if (rxEdge) begin
            rxSr_q <= shNext;
            if (rxState_q == RX_FRAME && !locked_q) begin
                // First sync found: purged, count next byte
                locked_q <= shNext == SYNC_CHAR; // RQ6 RQ9
            end else begin
                bitCnt_q <= bitCnt_q + 3'h1;
            end
        end
    end

    // Received byte hold, parity, error and request
    assign rxLoad = byteDone && (rxState_q == RX_RUN || shNext == SYNC_CHAR);
    assign rxLate = rxLoad && rxFull_q && !rdAck;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxHold_q <= 8'h00;
            parity_q <= 1'b0;
            rxFull_q <= 1'b0;
        end else if (rxLoad && !rxLate) begin
            rxHold_q <= shNext; // RQ12
            parity_q <= ~^shNext; // RQ2
            rxFull_q <= 1'b1;
        end else if (rdAck) begin
            rxFull_q <= 1'b0; // RQ9
        end
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            inErr_q <= 1'b0;
            inReq_q <= 1'b0;
        end else begin
            if (rxLate) inErr_q <= 1'b1; // RQ10
            else if (inStRd) inErr_q <= 1'b0;
            if (rxLoad) inReq_q <= 1'b1; // RQ1 RQ7
            else if (rdAck || cmdIn) inReq_q <= 1'b0;
        end
    end
    assign inSvcReq = inReq_q && inEn_q; // RQ22

    // Holding register and auto-dial digit
    assign tx.bitTick = txEdge;
    assign tx.byteIn = holdByte_q;
    assign tx.load = holdFull_q && tx.ready && ctsS && rts_q; // RQ14
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            holdFull_q <= 1'b0;
            holdByte_q <= 8'h00;
            dialDigit_q <= 4'h0;
            dialPend_q <= 1'b0;
        end else begin
            if (wrAck && dialMode_q) begin
                dialDigit_q <= acc[11:8]; // RQ18
            end else if (wrAck) begin
                holdByte_q <= acc[15:8];
                holdFull_q <= 1'b1;
            end else if (tx.load) begin
                holdFull_q <= 1'b0; // RQ14
            end
            if (nextEdge && dialMode_q) dialPend_q <= 1'b1; // RQ19
            else if (wrAck || !dialMode_q) dialPend_q <= 1'b0;
        end
    end

    // Output request, lateness count and output error
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            outReq_q <= 1'b0;
            txWait_q <= 1'b0;
            lateCnt_q <= 3'h0;
            outErr_q <= 1'b0;
        end else begin
            if (tx.load || (nextEdge && dialMode_q) || dsrEdge) begin
                outReq_q <= 1'b1; // RQ14 RQ19
            end else if (wrAck || outCmdAck) begin
                outReq_q <= 1'b0;
            end
            if (tx.load) begin
                txWait_q <= 1'b1;
                lateCnt_q <= 3'h0;
            end else if (wrAck || !rts_q) begin
                txWait_q <= 1'b0;
            end else if (txWait_q && txEdge) begin
                lateCnt_q <= lateCnt_q + 3'h1;
            end
            if (txWait_q && txEdge && !wrAck
                && lateCnt_q == LATE_BITS - 3'h1) begin
                outErr_q <= 1'b1; // RQ15
                txWait_q <= 1'b0;
            end else if (outStRd) begin
                outErr_q <= 1'b0;
            end
        end
    end
    assign outSvcReq = outReq_q && outEn_q; // RQ22

    smc_tx_shift u_shift (
        .clock(clock),
        .reset_n(reset_n),
        .tx(tx.shf)
    );
    assign txData = tx.txBit;
    assign requestToSend = rts_q;
    assign terminalReady = dtr_q;
    assign dialDigit = dialDigit_q;

    // Checks next to the logic
    property p_inreq;
        @(posedge clock) disable iff (!reset_n) rxLoad |=> inReq_q;
    endproperty
    a_inreq: assert property (p_inreq) // RQ1
        else $error("no input request after byte");
    property p_parity;
        @(posedge clock) disable iff (!reset_n)
        rxLoad && !rxLate |=> parity_q == ~^rxHold_q;
    endproperty
    a_parity: assert property (p_parity) // RQ2
        else $error("parity flag wrong");
    property p_idle;
        @(posedge clock) disable iff (!reset_n)
        !carrierS |=> rxState_q == RX_IDLE;
    endproperty
    a_idle: assert property (p_idle) // RQ3
        else $error("input not idle on carrier off");
    property p_arm;
        @(posedge clock) disable iff (!reset_n)
        rxState_q == RX_IDLE && carrierS |=> rxState_q == RX_ARMED;
    endproperty
    a_arm: assert property (p_arm) // RQ4
        else $error("input not armed on carrier");
    property p_frame;
        @(posedge clock) disable iff (!reset_n)
        rxState_q == RX_ARMED && carrierS && prev_q[1] && !rxDataS
        |=> rxState_q == RX_FRAME;
    endproperty
    a_frame: assert property (p_frame) // RQ5
        else $error("no framing on falling data");
    property p_fail;
        @(posedge clock) disable iff (!reset_n)
        rxState_q == RX_FRAME && carrierS && byteDone && !rsep
        && shNext != SYNC_CHAR |=> rxState_q == RX_ARMED && !$rose(inReq_q);
    endproperty
    a_fail: assert property (p_fail) // RQ7
        else $error("bad second sync not rejected");
    property p_late;
        @(posedge clock) disable iff (!reset_n)
        rxLate |=> inErr_q && rxHold_q == $past(rxHold_q);
    endproperty
    a_late: assert property (p_late) // RQ10
        else $error("input overrun not flagged");
    property p_rd;
        @(posedge clock) disable iff (!reset_n)
        rdAck |=> result_q[15:8] == $past(rxHold_q, 1)
        && result_q[7:0] == 8'h00 && (!rxFull_q || $past(rxLoad));
    endproperty
    a_rd: assert property (p_rd) // RQ11
        else $error("data read word wrong");
    property p_rdno;
        @(posedge clock) disable iff (!reset_n)
        instrGo && op == OP_DRD && toIn && hit && inErr_q
        |=> !result_q[RES_ACK];
    endproperty
    a_rdno: assert property (p_rdno) // RQ23
        else $error("read acked with input error");
    property p_oerr;
        @(posedge clock) disable iff (!reset_n)
        txWait_q && txEdge && !wrAck && lateCnt_q == 3'h6 |=> outErr_q;
    endproperty
    a_oerr: assert property (p_oerr) // RQ15
        else $error("output lateness not flagged");
    property p_dial;
        @(posedge clock) disable iff (!reset_n)
        wrAck && dialMode_q |=> dialDigit_q == $past(acc[11:8]) && !dialPend_q;
    endproperty
    a_dial: assert property (p_dial) // RQ18
        else $error("dial digit wrong");
    c_run: cover property (@(posedge clock) rxState_q == RX_RUN);
    c_err: cover property (@(posedge clock) outErr_q);
    c_send: cover property (@(posedge clock) tx.load ##[1:200] wrAck);
endmodule
`default_nettype wire

// file: dv/smc_modem_model.sv
// Modem partner: receive stream, transmit clock, line controls
`timescale 1ns/1ps
`default_nettype none
module smc_modem_model (
    output logic rxClk, // Receive clock
    output logic rxData, // Receive data
    output logic carrierOn, // Carrier detect
    output logic txClk, // Transmit clock
    output logic clearToSend, // Clear to send
    output logic dataSetReady // Data set ready
);
    // Lines start quiet, data at mark
    initial begin
        {rxClk, carrierOn, clearToSend, dataSetReady, txClk} = 5'h00;
        rxData = 1'b1;
    end
    // Transmit clock runs free
    always #62.5 txClk = ~txClk;
    // One byte, leading bit first, clock only within the frame
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            rxData = b[i];
            #62.5 rxClk = 1'b1;
            #62.5 rxClk = 1'b0;
        end
        rxData = ~b[0];
    endtask
endmodule
`default_nettype wire

// file: dv/smc_ctrl_tb_top.sv
// Testbench for the sync modem character controller
`timescale 1ns/1ps
`default_nettype none
module smc_ctrl_tb_top;
    import smc_pkg::*;
    localparam logic [7:0] IA = 8'h43;
    localparam logic [7:0] OA = 8'h42;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, r;
    logic [1:0] bresp, rresp, rr;
    logic awready, wready, bvalid, arready, rvalid, txData, inSvcReq, outSvcReq;
    logic rxClk, rxData, carrierOn, txClk, clearToSend, dataSetReady;
    int n_fail = 0, checks = 0;
    // Rows: byte beside its parity flag
    logic [8:0] rows [4] = '{9'h14B, 9'h002, 9'h1FF, 9'h100};
    smc_modem_model i_mdl (.rxClk(rxClk), .rxData(rxData),
        .carrierOn(carrierOn), .txClk(txClk), .clearToSend(clearToSend),
        .dataSetReady(dataSetReady));
    smc_ctrl i_dut (.clock(clock), .reset_n(reset_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rxClk(rxClk), .rxData(rxData),
        .carrierOn(carrierOn), .txClk(txClk), .clearToSend(clearToSend),
        .dataSetReady(dataSetReady), .dialNextReq(1'b0), .txData(txData),
        .requestToSend(), .terminalReady(), .dialDigit(),
        .inSvcReq(inSvcReq), .outSvcReq(outSvcReq));
    // System clock
    always #2.5 clock = ~clock;
    task automatic complete_run(input int t);
        n_fail += t;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Bus cycles: each channel released at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        tb = 1'b0;
        for (int n = 0; n < 100 && !tb; n++) begin
            @(negedge clock);
            {ta, tw, tb} = {awready, wready, bvalid};
            @(posedge clock);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        if (!tb) complete_run(1);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        tr = 1'b0;
        for (int n = 0; n < 100 && !tr; n++) begin
            @(negedge clock);
            {ta, tr, r, rr} = {arready, rvalid, rdata, rresp};
            @(posedge clock);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!tr) complete_run(1);
    endtask
    task automatic io(input logic [1:0] op, input logic [7:0] a,
                      input logic [15:0] acc);
        wr(OFF_INSTR, {op, 6'h00, a, acc});
        rd(OFF_RESULT);
    endtask
    task automatic wsvc();
        int n;
        @(posedge clock);
        for (n = 0; n < 1000 && inSvcReq !== 1'b1; n++) @(posedge clock);
        if (n == 1000) complete_run(1);
    endtask
    // Main sequence
    initial begin
        logic [7:0] b;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        chk(txData, 1);
        rd(8'h0C);
        chk(rr, RESP_SLVERR);
        i_mdl.carrierOn <= 1'b1;
        repeat (6) @(posedge clock);
        rd(OFF_STATUS);
        chk(r[7:6], 1);
        io(OP_CMD, IA, {12'h000, CMD_ALW});
        chk(r[RES_ACK], 1);
        i_mdl.send(8'h16);
        rd(OFF_STATUS);
        chk(r[5:2], 4'h8);
        i_mdl.send(8'h16);
        wsvc();
        rd(OFF_STATUS);
        chk(r[7:6], 3);
        io(OP_DRD, IA, 16'h0000);
        chk(r[16:0], 17'h11600);
        for (int i = 0; i < 4; i++) begin
            i_mdl.send(rows[i][8:1]);
            wsvc();
            io(OP_SRD, IA, 16'h0000);
            chk(r[ST_PAR], rows[i][0]);
            io(OP_DRD, IA, 16'h0000);
            chk(r[16:0], {1'b1, rows[i][8:1], 8'h00});
        end
        i_mdl.send(8'h33);
        i_mdl.send(8'h44);
        wsvc();
        io(OP_DRD, IA, 16'h0000);
        chk(r[RES_ACK], 0);
        io(OP_SRD, IA, 16'h0000);
        chk(r[ST_ERR], 1);
        io(OP_CMD, IA, {12'h000, CMD_ONE});
        i_mdl.send(8'h16);
        i_mdl.send(8'h54);
        rd(OFF_STATUS);
        chk(r[7:2], 6'h14);
        i_mdl.carrierOn <= 1'b0;
        repeat (6) @(posedge clock);
        rd(OFF_STATUS);
        chk(r[7:6], 0);
        i_mdl.dataSetReady <= 1'b1;
        i_mdl.clearToSend <= 1'b1;
        repeat (6) @(posedge clock);
        io(OP_CMD, OA, {12'h000, CMD_ONE});
        io(OP_DWR, OA, 16'h5A00);
        chk(r[RES_ACK], 1);
        @(posedge txClk);
        for (int n = 0; n < 40 && txData !== 1'b0; n++) @(posedge txClk);
        for (int n = 0; n < 8; n++) begin
            b = {b[6:0], txData};
            @(posedge txClk);
        end
        chk(b, 8'h5A);
        chk(txData, 1);
        repeat (8) @(posedge txClk);
        @(posedge clock);
        io(OP_SRD, OA, 16'h0000);
        chk(r[ST_ERR], 1);
        chk(outSvcReq, 0);
        io(OP_CMD, OA, {12'h000, CMD_DONE});
        complete_run(0);
    end
endmodule
`default_nettype wire
